// ===== hdl/dtpb_bank.sv
// Threshold register bank and intelligent output flag logic
`timescale 1ns/1ps

// Operation
// - Low-current mode 0 any phase, 1 constant speed
// - Low-current level 0..1800, tenth percent steps
// - Overload mode 0 any phase, 1 constant speed
// - Overload level 0..1800, tenth percent steps
// - Accel arrival hi/lo pair, 0..40000, compared accelerating
// - Decel arrival hi/lo pair, 0..40000, compared decelerating
// - Deviation flag when setpoint-feedback magnitude exceeds level
// - Feedback maximum holds 0..1000
// - Feedback minimum holds 0..1000
// - Per-quadrant over-torque thresholds, consecutive addresses
// - Quadrant thresholds accept 0..180 percent
// - Second accel/decel arrival pairs, 0..40000
module dtpb_bank
  import dtpb_pkg::*;
(
  input wire logic clk, // System clock, 200 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [15:0] reg_addr, // Holding register number
  input wire logic [15:0] reg_wdata, // Write data
  output logic [15:0] reg_rdata, // Read data, registered
  output logic reg_rvalid, // Read data valid pulse
  output logic reg_wack, // Write acknowledge pulse
  output logic reg_werr, // Write refused pulse
  input wire logic [15:0] drive_current, // Output current, 0.1 % of rated
  input wire logic [31:0] output_freq, // Output frequency, 0.01 Hz
  input wire logic accelerating, // Drive is accelerating
  input wire logic decelerating, // Drive is decelerating
  input wire logic [15:0] process_setpoint, // PID setpoint, 0.1 %
  input wire logic [15:0] process_feedback, // PID feedback, 0.1 %
  input wire logic [15:0] torque_level, // Torque magnitude, 1 %
  input wire logic [1:0] torque_quadrant, // Operating quadrant
  output logic low_current_flag, // Current below low-current level
  output logic overload_flag, // Current above overload level
  output logic accel_arrival_flag, // Arrival reached while accelerating
  output logic decel_arrival_flag, // Arrival reached while decelerating
  output logic accel_arrival2_flag, // Second accel arrival reached
  output logic decel_arrival2_flag, // Second decel arrival reached
  output logic pid_deviation_flag, // PID error beyond level
  output logic over_torque_flag, // Torque beyond quadrant level
  output logic [15:0] feedback_max, // Feedback scaling maximum
  output logic [15:0] feedback_min, // Feedback scaling minimum
  output logic arrival_pending // A pair awaits its low word
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Absolute difference of two unsigned words
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] r;
    r = (a > b) ? (a - b) : (b - a);
    return r;
  endfunction

  // Upper limit of a single-word register; zero marks unmapped
  function automatic logic [16:0] word_limit(input logic [15:0] addr);
    logic [16:0] r;
    r = 17'h00000;
    case (addr)
      DTPB_ADDR_LC_MODE: r = {1'b1, DTPB_MAX_MODE};
      DTPB_ADDR_OL_MODE: r = {1'b1, DTPB_MAX_MODE};
      DTPB_ADDR_LC_LEVEL: r = {1'b1, DTPB_MAX_CURRENT};
      DTPB_ADDR_OL_LEVEL: r = {1'b1, DTPB_MAX_CURRENT};
      DTPB_ADDR_PID_LEVEL: r = {1'b1, DTPB_MAX_PERMILLE};
      DTPB_ADDR_FB_MAX: r = {1'b1, DTPB_MAX_PERMILLE};
      DTPB_ADDR_FB_MIN: r = {1'b1, DTPB_MAX_PERMILLE};
      DTPB_ADDR_TQ1: r = {1'b1, DTPB_MAX_TORQUE};
      DTPB_ADDR_TQ2: r = {1'b1, DTPB_MAX_TORQUE};
      DTPB_ADDR_TQ3: r = {1'b1, DTPB_MAX_TORQUE};
      DTPB_ADDR_TQ4: r = {1'b1, DTPB_MAX_TORQUE};
      default: r = 17'h00000;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------

  logic [15:0] lc_mode_q;
  logic [15:0] lc_level_q;
  logic [15:0] ol_mode_q;
  logic [15:0] ol_level_q;
  logic [15:0] pid_level_q;
  logic [15:0] fb_max_q;
  logic [15:0] fb_min_q;
  logic [15:0] torque_q [4];

  logic [16:0] limit;
  logic word_hit;
  logic word_ok;
  logic wr_acc_hi;
  logic wr_acc_lo;
  logic wr_dec_hi;
  logic wr_dec_lo;
  logic wr_acc2_hi;
  logic wr_acc2_lo;
  logic wr_dec2_hi;
  logic wr_dec2_lo;
  logic [31:0] acc_thr;
  logic [31:0] dec_thr;
  logic [31:0] acc2_thr;
  logic [31:0] dec2_thr;
  logic [15:0] acc_stage;
  logic [15:0] dec_stage;
  logic [15:0] acc2_stage;
  logic [15:0] dec2_stage;
  logic [3:0] pair_pending;
  logic [3:0] pair_reject;
  logic pair_hit;
  logic pair_bad;
  logic [15:0] rdata_d;

  // Write decode, single-word registers
  assign limit = word_limit(reg_addr);
  assign word_hit = limit[16];
  assign word_ok = reg_wr && word_hit && (reg_wdata <= limit[15:0]);

  // Write decode, word-pair registers
  assign wr_acc_hi = reg_wr && (reg_addr == DTPB_ADDR_ACC_HI);
  assign wr_acc_lo = reg_wr && (reg_addr == DTPB_ADDR_ACC_LO);
  assign wr_dec_hi = reg_wr && (reg_addr == DTPB_ADDR_DEC_HI);
  assign wr_dec_lo = reg_wr && (reg_addr == DTPB_ADDR_DEC_LO);
  assign wr_acc2_hi = reg_wr && (reg_addr == DTPB_ADDR_ACC2_HI);
  assign wr_acc2_lo = reg_wr && (reg_addr == DTPB_ADDR_ACC2_LO);
  assign wr_dec2_hi = reg_wr && (reg_addr == DTPB_ADDR_DEC2_HI);
  assign wr_dec2_lo = reg_wr && (reg_addr == DTPB_ADDR_DEC2_LO);
  assign pair_hit = wr_acc_hi | wr_acc_lo | wr_dec_hi | wr_dec_lo
                  | wr_acc2_hi | wr_acc2_lo | wr_dec2_hi | wr_dec2_lo;
  assign pair_bad = |pair_reject;

  // Mode selects
  always_ff @(posedge clk) begin
    if (rst) begin
      lc_mode_q <= DTPB_RST_WORD;
      ol_mode_q <= DTPB_RST_WORD;
    end else if (ce && word_ok) begin
      if (reg_addr == DTPB_ADDR_LC_MODE) begin
        lc_mode_q <= reg_wdata;
      end
      if (reg_addr == DTPB_ADDR_OL_MODE) begin
        ol_mode_q <= reg_wdata;
      end
    end
  end

  // Current levels
  always_ff @(posedge clk) begin
    if (rst) begin
      lc_level_q <= DTPB_RST_WORD;
      ol_level_q <= DTPB_RST_WORD;
    end else if (ce && word_ok) begin
      if (reg_addr == DTPB_ADDR_LC_LEVEL) begin
        lc_level_q <= reg_wdata;
      end
      if (reg_addr == DTPB_ADDR_OL_LEVEL) begin
        ol_level_q <= reg_wdata;
      end
    end
  end

  // PID deviation level and feedback scaling
  always_ff @(posedge clk) begin
    if (rst) begin
      pid_level_q <= DTPB_RST_WORD;
      fb_max_q <= DTPB_RST_WORD;
      fb_min_q <= DTPB_RST_WORD;
    end else if (ce && word_ok) begin
      if (reg_addr == DTPB_ADDR_PID_LEVEL) begin
        pid_level_q <= reg_wdata;
      end
      if (reg_addr == DTPB_ADDR_FB_MAX) begin
        fb_max_q <= reg_wdata;
      end
      if (reg_addr == DTPB_ADDR_FB_MIN) begin
        fb_min_q <= reg_wdata;
      end
    end
  end

  // Over-torque levels, one per quadrant at consecutive addresses
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        torque_q[i] <= DTPB_RST_WORD;
      end
    end else if (ce && word_ok) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_addr == DTPB_ADDR_TQ1 + 16'(i)) begin
          torque_q[i] <= reg_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Arrival threshold pairs
  // ----------------------------------------------------------------

  dtpb_word_pair #(.MAX_VALUE(DTPB_MAX_ARRIVAL)) u_acc (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_hi(wr_acc_hi),
    .wr_lo(wr_acc_lo),
    .wdata(reg_wdata),
    .value(acc_thr),
    .stage_hi(acc_stage),
    .pending(pair_pending[0]),
    .reject(pair_reject[0])
  );

  dtpb_word_pair #(.MAX_VALUE(DTPB_MAX_ARRIVAL)) u_dec (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_hi(wr_dec_hi),
    .wr_lo(wr_dec_lo),
    .wdata(reg_wdata),
    .value(dec_thr),
    .stage_hi(dec_stage),
    .pending(pair_pending[1]),
    .reject(pair_reject[1])
  );

  dtpb_word_pair #(.MAX_VALUE(DTPB_MAX_ARRIVAL)) u_acc2 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_hi(wr_acc2_hi),
    .wr_lo(wr_acc2_lo),
    .wdata(reg_wdata),
    .value(acc2_thr),
    .stage_hi(acc2_stage),
    .pending(pair_pending[2]),
    .reject(pair_reject[2])
  );

  dtpb_word_pair #(.MAX_VALUE(DTPB_MAX_ARRIVAL)) u_dec2 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_hi(wr_dec2_hi),
    .wr_lo(wr_dec2_lo),
    .wdata(reg_wdata),
    .value(dec2_thr),
    .stage_hi(dec2_stage),
    .pending(pair_pending[3]),
    .reject(pair_reject[3])
  );

  // ----------------------------------------------------------------
  // Register access responses
  // ----------------------------------------------------------------

  // Read mux; committed halves are returned, reserved reads give zero
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      DTPB_ADDR_LC_MODE: rdata_d = lc_mode_q;
      DTPB_ADDR_LC_LEVEL: rdata_d = lc_level_q;
      DTPB_ADDR_OL_MODE: rdata_d = ol_mode_q;
      DTPB_ADDR_OL_LEVEL: rdata_d = ol_level_q;
      DTPB_ADDR_ACC_HI: rdata_d = acc_thr[31:16];
      DTPB_ADDR_ACC_LO: rdata_d = acc_thr[15:0];
      DTPB_ADDR_DEC_HI: rdata_d = dec_thr[31:16];
      DTPB_ADDR_DEC_LO: rdata_d = dec_thr[15:0];
      DTPB_ADDR_PID_LEVEL: rdata_d = pid_level_q;
      DTPB_ADDR_ACC2_HI: rdata_d = acc2_thr[31:16];
      DTPB_ADDR_ACC2_LO: rdata_d = acc2_thr[15:0];
      DTPB_ADDR_DEC2_HI: rdata_d = dec2_thr[31:16];
      DTPB_ADDR_DEC2_LO: rdata_d = dec2_thr[15:0];
      DTPB_ADDR_FB_MAX: rdata_d = fb_max_q;
      DTPB_ADDR_FB_MIN: rdata_d = fb_min_q;
      DTPB_ADDR_TQ1: rdata_d = torque_q[0];
      DTPB_ADDR_TQ2: rdata_d = torque_q[1];
      DTPB_ADDR_TQ3: rdata_d = torque_q[2];
      DTPB_ADDR_TQ4: rdata_d = torque_q[3];
      default: rdata_d = 16'h0000;
    endcase
  end

  // Read data and valid, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // Write acknowledge; refused when out of range or not mapped
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_wack <= 1'b0;
      reg_werr <= 1'b0;
    end else if (ce) begin
      reg_wack <= reg_wr;
      reg_werr <= reg_wr && ((word_hit && !word_ok) || pair_bad
                             || (!word_hit && !pair_hit));
    end
  end

  // ----------------------------------------------------------------
  // Flag logic
  // ----------------------------------------------------------------

  logic const_speed;
  logic [15:0] pid_err;
  logic [15:0] tq_sel;

  assign const_speed = !accelerating && !decelerating;
  assign pid_err = abs_diff(process_setpoint, process_feedback);

  // Threshold for the present quadrant
  always_comb begin
    case (dtpb_quad_e'(torque_quadrant))
      DTPB_QUAD_FWD_DRIVE: tq_sel = torque_q[0];
      DTPB_QUAD_REV_REGEN: tq_sel = torque_q[1];
      DTPB_QUAD_REV_DRIVE: tq_sel = torque_q[2];
      DTPB_QUAD_FWD_REGEN: tq_sel = torque_q[3];
      default: tq_sel = torque_q[0];
    endcase
  end

  // Current flags, gated by their mode selects
  always_ff @(posedge clk) begin
    if (rst) begin
      low_current_flag <= 1'b0;
      overload_flag <= 1'b0;
    end else if (ce) begin
      low_current_flag <= (drive_current < lc_level_q)
                          && (lc_mode_q[0] == 1'b0 || const_speed);
      overload_flag <= (drive_current > ol_level_q)
                       && (ol_mode_q[0] == 1'b0 || const_speed);
    end
  end

  // Frequency arrival flags
  always_ff @(posedge clk) begin
    if (rst) begin
      accel_arrival_flag <= 1'b0;
      decel_arrival_flag <= 1'b0;
      accel_arrival2_flag <= 1'b0;
      decel_arrival2_flag <= 1'b0;
    end else if (ce) begin
      accel_arrival_flag <= accelerating && (output_freq >= acc_thr);
      decel_arrival_flag <= decelerating && (output_freq <= dec_thr);
      accel_arrival2_flag <= accelerating && (output_freq >= acc2_thr);
      decel_arrival2_flag <= decelerating && (output_freq <= dec2_thr);
    end
  end

  // PID deviation and over-torque flags
  always_ff @(posedge clk) begin
    if (rst) begin
      pid_deviation_flag <= 1'b0;
      over_torque_flag <= 1'b0;
    end else if (ce) begin
      pid_deviation_flag <= (pid_err > pid_level_q);
      over_torque_flag <= (torque_level > tq_sel);
    end
  end

  // Status outputs
  assign feedback_max = fb_max_q;
  assign feedback_min = fb_min_q;
  assign arrival_pending = |pair_pending;

endmodule

// ===== hdl/dtpb_pkg.sv
// Package with addresses, ranges and reset values of the threshold bank
package dtpb_pkg;

  // ----------------------------------------------------------------
  // Register addresses (holding-register numbers)
  // ----------------------------------------------------------------
  localparam logic [15:0] DTPB_ADDR_BANK_FIRST = 16'h1425;
  localparam logic [15:0] DTPB_ADDR_LC_MODE = 16'h1426;
  localparam logic [15:0] DTPB_ADDR_LC_LEVEL = 16'h1427;
  localparam logic [15:0] DTPB_ADDR_OL_MODE = 16'h1428;
  localparam logic [15:0] DTPB_ADDR_OL_LEVEL = 16'h1429;
  localparam logic [15:0] DTPB_ADDR_ACC_HI = 16'h142a;
  localparam logic [15:0] DTPB_ADDR_ACC_LO = 16'h142b;
  localparam logic [15:0] DTPB_ADDR_DEC_HI = 16'h142c;
  localparam logic [15:0] DTPB_ADDR_DEC_LO = 16'h142d;
  localparam logic [15:0] DTPB_ADDR_PID_LEVEL = 16'h142e;
  localparam logic [15:0] DTPB_ADDR_ACC2_HI = 16'h142f;
  localparam logic [15:0] DTPB_ADDR_ACC2_LO = 16'h1430;
  localparam logic [15:0] DTPB_ADDR_DEC2_HI = 16'h1431;
  localparam logic [15:0] DTPB_ADDR_DEC2_LO = 16'h1432;
  localparam logic [15:0] DTPB_ADDR_FB_MAX = 16'h1438;
  localparam logic [15:0] DTPB_ADDR_FB_MIN = 16'h1439;
  localparam logic [15:0] DTPB_ADDR_TQ1 = 16'h143b;
  localparam logic [15:0] DTPB_ADDR_TQ2 = 16'h143c;
  localparam logic [15:0] DTPB_ADDR_TQ3 = 16'h143d;
  localparam logic [15:0] DTPB_ADDR_TQ4 = 16'h143e;
  localparam logic [15:0] DTPB_ADDR_BANK_LAST = 16'h143e;

  // ----------------------------------------------------------------
  // Upper limits of accepted values
  // ----------------------------------------------------------------
  localparam logic [15:0] DTPB_MAX_MODE = 16'h0001;
  localparam logic [15:0] DTPB_MAX_CURRENT = 16'h0708;
  localparam logic [31:0] DTPB_MAX_ARRIVAL = 32'h00009c40;
  localparam logic [15:0] DTPB_MAX_PERMILLE = 16'h03e8;
  localparam logic [15:0] DTPB_MAX_TORQUE = 16'h00b4;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] DTPB_RST_WORD = 16'h0000;
  localparam logic [31:0] DTPB_RST_PAIR = 32'h00000000;

  // Operating quadrant of the drive, Gray coded around I-II-III-IV
  typedef enum logic [1:0] {
    DTPB_QUAD_FWD_DRIVE = 2'b00,
    DTPB_QUAD_REV_REGEN = 2'b01,
    DTPB_QUAD_REV_DRIVE = 2'b11,
    DTPB_QUAD_FWD_REGEN = 2'b10
  } dtpb_quad_e;

endpackage

// ===== hdl/dtpb_word_pair.sv
// Two-word threshold register with staged high word and atomic commit
`timescale 1ns/1ps

module dtpb_word_pair
  import dtpb_pkg::*;
#(
  parameter logic [31:0] MAX_VALUE = DTPB_MAX_ARRIVAL
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic wr_hi, // Write strobe, high word
  input wire logic wr_lo, // Write strobe, low word
  input wire logic [15:0] wdata, // Write data
  output logic [31:0] value, // Committed threshold
  output logic [15:0] stage_hi, // Staged high word
  output logic pending, // High word staged, low not yet written
  output logic reject // Current write is out of range
);

  logic [31:0] value_q;
  logic [15:0] stage_q;
  logic pending_q;
  logic [31:0] joined;

  // Candidate value formed from staged high and incoming low word
  assign joined = {stage_q, wdata};

  // Range check on both halves
  always_comb begin
    reject = 1'b0;
    if (wr_hi && (wdata > MAX_VALUE[31:16])) begin
      reject = 1'b1;
    end else if (wr_lo && (joined > MAX_VALUE)) begin
      reject = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Staging and commit
  // ----------------------------------------------------------------

  // High word waits in stage until low word arrives
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_q <= DTPB_RST_PAIR[31:16];
      pending_q <= 1'b0;
    end else if (ce) begin
      if (wr_hi && !reject) begin
        stage_q <= wdata;
        pending_q <= 1'b1;
      end else if (wr_lo && !reject) begin
        pending_q <= 1'b0;
      end
    end
  end

  // Threshold changes only on an accepted low-word write
  always_ff @(posedge clk) begin
    if (rst) begin
      value_q <= DTPB_RST_PAIR;
    end else if (ce && wr_lo && !reject) begin
      value_q <= joined;
    end
  end

  assign value = value_q;
  assign stage_hi = stage_q;
  assign pending = pending_q;

endmodule

// ===== testbench/dtpb_bank_checker.sv
// Concurrent checks on the threshold bank ports
`timescale 1ns/1ps

module dtpb_bank_checker
  import dtpb_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_addr, // Register number
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read answer
  input wire logic reg_wack, // Write answer
  input wire logic reg_werr, // Write refused
  input wire logic accelerating, // Accelerating phase
  input wire logic [15:0] process_setpoint, // PID setpoint
  input wire logic [15:0] process_feedback, // PID feedback
  input wire logic accel_arrival_flag, // Accel arrival flag
  input wire logic pid_deviation_flag, // Deviation flag
  input wire logic [15:0] feedback_max, // Feedback maximum
  input wire logic arrival_pending // Pair awaits low word
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Addresses inside the bank that hold nothing
  logic rsv;
  assign rsv = reg_addr == DTPB_ADDR_BANK_FIRST || reg_addr == 16'h143a
    || (reg_addr >= 16'h1433 && reg_addr <= 16'h1437);

  // High word of zero written to the first accel pair
  sequence s_hi_write;
    ce && reg_wr && reg_addr == DTPB_ADDR_ACC_HI && reg_wdata == 16'h0000;
  endsequence

  // Accepted and staged one cycle later
  sequence s_staged;
    ##1 reg_wack && !reg_werr && arrival_pending;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wack_follows_wr: assert property (ce && reg_wr |=> reg_wack)
    else $error("write not acknowledged");
  a_rvalid_follows_rd: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_werr_with_wack: assert property (reg_werr |-> reg_wack)
    else $error("refusal without acknowledge");
  a_rsv_read_zero: assert property (ce && reg_rd && rsv |=> reg_rdata == 16'h0000)
    else $error("reserved read not zero");
  a_rsv_write_err: assert property (ce && reg_wr && rsv |=> reg_werr)
    else $error("reserved write not refused");
  a_range_reject: assert property (ce && reg_wr && ((reg_addr == DTPB_ADDR_LC_LEVEL
    && reg_wdata > DTPB_MAX_CURRENT) || (reg_addr == DTPB_ADDR_LC_MODE
    && reg_wdata > DTPB_MAX_MODE)) |=> reg_werr)
    else $error("out of range write accepted");
  a_fb_store_max: assert property (ce && reg_wr && reg_addr == DTPB_ADDR_FB_MAX
    && reg_wdata <= DTPB_MAX_PERMILLE |=> !reg_werr && feedback_max == $past(reg_wdata))
    else $error("feedback maximum not stored");
  a_pair_hi_staged: assert property (s_hi_write |-> s_staged)
    else $error("high word not staged");
  a_accel_phase_only: assert property (accel_arrival_flag |-> $past(accelerating))
    else $error("accel arrival outside acceleration");
  a_pid_needs_error: assert property (pid_deviation_flag
    |-> $past(process_setpoint) != $past(process_feedback))
    else $error("deviation flag without error");
  a_rdata_hold_idle: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule

bind dtpb_bank dtpb_bank_checker chk (.*);

// ===== testbench/dtpb_net_master.sv
// Network master model issuing holding-register reads and writes
`timescale 1ns/1ps

module dtpb_net_master (
  input wire logic clk, // System clock
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [15:0] reg_addr, // Register number
  output logic [15:0] reg_wdata, // Write data
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read answer
  input wire logic reg_wack, // Write answer
  input wire logic reg_werr // Write refused
);
  // Idle bus from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // One transfer; released address and data lines show the inverse of the last value
  task automatic xfer(input logic w, input logic [15:0] a, d, output logic e,
    output logic [15:0] q);
    int i;
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    i = 0;
    while ((w ? reg_wack : reg_rvalid) !== 1'b1 && i < 4) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i == 4) dtpb_bank_tb.stall();
    e = reg_werr;
    q = reg_rdata;
  endtask

  // Write wrapper
  task automatic wr(input logic [15:0] a, d, output logic e);
    logic [15:0] q;
    xfer(1'b1, a, d, e, q);
  endtask

  // Read wrapper
  task automatic rd(input logic [15:0] a, output logic [15:0] q);
    logic e;
    xfer(1'b0, a, 16'h0000, e, q);
  endtask
endmodule

// ===== testbench/dtpb_bank_tb.sv
// Self-checking bench for the threshold register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module dtpb_bank_tb;
  import dtpb_pkg::*;
  typedef struct packed {logic [15:0] a, d; logic e; logic [15:0] q;} dtpb_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, reg_wack, reg_werr, accelerating, decelerating, e;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, drive_current, process_setpoint, q;
  logic [15:0] process_feedback, torque_level, feedback_max, feedback_min, a;
  logic [31:0] output_freq;
  logic [1:0] torque_quadrant;
  logic arrival_pending;
  wire [7:0] fl;
  int err_total = 0;
  int n_tests = 0;
  // Write, then read back: address, data, refused, readback
  dtpb_row_s rows [$] = '{
    '{16'h1426, 16'h1, 1'b0, 16'h1}, '{16'h1426, 16'h2, 1'b1, 16'h1},
    '{16'h1427, 16'h708, 1'b0, 16'h708}, '{16'h1427, 16'h709, 1'b1, 16'h708},
    '{16'h1428, 16'h1, 1'b0, 16'h1}, '{16'h1428, 16'hffff, 1'b1, 16'h1},
    '{16'h1429, 16'h708, 1'b0, 16'h708}, '{16'h1429, 16'h709, 1'b1, 16'h708},
    '{16'h142a, 16'h1, 1'b1, 16'h0}, '{16'h142b, 16'h9c40, 1'b0, 16'h9c40},
    '{16'h142b, 16'h9c41, 1'b1, 16'h9c40}, '{16'h142d, 16'h9c41, 1'b1, 16'h0},
    '{16'h142d, 16'h9c40, 1'b0, 16'h9c40}, '{16'h142e, 16'h3e8, 1'b0, 16'h3e8},
    '{16'h142e, 16'h3e9, 1'b1, 16'h3e8}, '{16'h1430, 16'h9c40, 1'b0, 16'h9c40},
    '{16'h1432, 16'h9c41, 1'b1, 16'h0}, '{16'h1438, 16'h3e8, 1'b0, 16'h3e8},
    '{16'h1438, 16'h3e9, 1'b1, 16'h3e8}, '{16'h1439, 16'h3e9, 1'b1, 16'h0},
    '{16'h143b, 16'hb4, 1'b0, 16'hb4}, '{16'h143c, 16'hb5, 1'b1, 16'h0},
    '{16'h143d, 16'hb4, 1'b0, 16'hb4}, '{16'h143e, 16'hb5, 1'b1, 16'h0},
    '{16'h1425, 16'h5, 1'b1, 16'h0}, '{16'h1433, 16'h1, 1'b1, 16'h0},
    '{16'h1437, 16'h1, 1'b1, 16'h0}, '{16'h143a, 16'h1, 1'b1, 16'h0},
    '{16'h1440, 16'h1, 1'b1, 16'h0}};

  // 200 MHz clock
  always #2.5 clk = ~clk;

  dtpb_bank dut (.*,
    .low_current_flag(fl[0]), .overload_flag(fl[1]), .accel_arrival_flag(fl[2]),
    .decel_arrival_flag(fl[3]), .accel_arrival2_flag(fl[4]), .decel_arrival2_flag(fl[5]),
    .pid_deviation_flag(fl[6]), .over_torque_flag(fl[7]));

  dtpb_net_master m (.*);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("Tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Hung transfer
  task automatic stall();
    err_total++;
    results();
  endtask

  // Reset held five cycles
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Drive the live quantities, let the flags catch up
  task automatic drv(input logic ac = 1'b0, dc = 1'b0, input logic [31:0] f = 32'h0,
    input logic [15:0] cur = 16'h0, sp = 16'h0, fb = 16'h0, tq = 16'h0,
    input logic [1:0] qd = 2'b00);
    @(posedge clk);
    accelerating <= ac;
    decelerating <= dc;
    output_freq <= f;
    drive_current <= cur;
    process_setpoint <= sp;
    process_feedback <= fb;
    torque_level <= tq;
    torque_quadrant <= qd;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Two-word threshold: zero high word, then low word
  task automatic wpair(input logic [15:0] ad, v);
    m.wr(ad, 16'h0000, e);
    `CHK("pending set", 1'b1, arrival_pending)
    m.wr(ad + 16'h0001, v, e);
    `CHK("pending clear", 1'b0, arrival_pending)
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    drv();
    do_reset();
    drv();
    `CHK("flags idle", 8'h00, fl)
    foreach (rows[i]) begin
      m.wr(rows[i].a, rows[i].d, e);
      `CHK("werr", rows[i].e, e)
      m.rd(rows[i].a, q);
      `CHK("rdata", rows[i].q, q)
    end
    `CHK("fb ports", 32'h03e80000, {feedback_max, feedback_min})
    // Mid-run reset clears the whole bank
    do_reset();
    for (a = 16'h1425; a <= 16'h143e; a++) begin
      m.rd(a, q);
      `CHK("reset value", 16'h0000, q)
    end
    // Arrival pairs 1000, 2000, 3000, 4000
    wpair(16'h142a, 16'h3e8);
    wpair(16'h142c, 16'h7d0);
    wpair(16'h142f, 16'hbb8);
    wpair(16'h1431, 16'hfa0);
    drv(1'b1, , 32'hbb8);
    `CHK("accel arrival", 4'b0101, fl[5:2])
    drv(1'b1, , 32'hbb7);
    `CHK("accel below", 4'b0001, fl[5:2])
    drv(, 1'b1, 32'h7d0);
    `CHK("decel arrival", 4'b1010, fl[5:2])
    drv(, 1'b1, 32'h7d1);
    `CHK("decel above", 4'b1000, fl[5:2])
    // Current levels 100 and 200, constant-speed modes
    m.wr(16'h1427, 16'h0064, e);
    m.wr(16'h1429, 16'h00c8, e);
    m.wr(16'h1426, 16'h0001, e);
    m.wr(16'h1428, 16'h0001, e);
    drv(1'b1, , , 16'h63);
    `CHK("lc mode1 accel", 2'b00, fl[1:0])
    drv(, , , 16'h63);
    `CHK("lc mode1 const", 2'b01, fl[1:0])
    drv(, 1'b1, , 16'hc9);
    `CHK("ol mode1 decel", 2'b00, fl[1:0])
    drv(, , , 16'hc9);
    `CHK("ol mode1 const", 2'b10, fl[1:0])
    m.wr(16'h1426, 16'h0000, e);
    m.wr(16'h1428, 16'h0000, e);
    drv(1'b1, , , 16'h63);
    `CHK("lc mode0 accel", 2'b01, fl[1:0])
    // Clock enable low holds the flags
    @(posedge clk) ce <= 1'b0;
    drv(, 1'b1, , 16'hc9);
    `CHK("ce frozen", 2'b01, fl[1:0])
    @(posedge clk) ce <= 1'b1;
    drv(, 1'b1, , 16'hc9);
    `CHK("ol mode0 decel", 2'b10, fl[1:0])
    // Deviation level 50, both signs of the error
    m.wr(16'h142e, 16'h0032, e);
    drv(, , , , 16'h64, 16'h96);
    `CHK("dev equal", 1'b0, fl[6])
    drv(, , , , 16'h64, 16'h97);
    `CHK("dev below", 1'b1, fl[6])
    drv(, , , , 16'hc8, 16'h95);
    `CHK("dev above", 1'b1, fl[6])
    // Distinct torque level per quadrant
    for (int k = 0; k < 4; k++) begin
      m.wr(16'h143b + 16'(k), 16'(10 * (k + 1)), e);
    end
    for (int k = 0; k < 4; k++) begin
      drv(, , , , , , 16'(10 * (k + 1)), 2'(k ^ (k >> 1)));
      `CHK("torque at level", 1'b0, fl[7])
      drv(, , , , , , 16'(10 * (k + 1) + 1), 2'(k ^ (k >> 1)));
      `CHK("torque over", 1'b1, fl[7])
    end
    results();
  end
endmodule
